// file: scrs_top.sv
`timescale 1ns/1ps
`include "scrs_consts.svh"

// What this block does
// - serial addresses 0x00 to 0x1B, 28 registers
// - same contents as 112 parallel byte registers
// - writes staged until update strobe or profile change
// - primary control register at serial address zero
// - bit 24 rising starts oscillator calibration
// - bit 17 low: parallel words only on strobe
// - bit 17 high: sample words every clock, routed
// - bit 16 selects sine, cosine when zero
// - bit 15 with ramp enable reloads ramp rate
// - bit 14 low: no ramp autoclear
// - bit 14 high: one-cycle ramp clear on transfer
// - master reset restores all register defaults
module scrs_top #(
    parameter int FIFO_DEPTH = `SCRS_FIFO_DEPTH
) (
    input  wire logic                          CLK_IN,
    input  wire logic                          ARST_N_IN,
    input  wire logic                          MASTER_RESET_IN,
    input  wire logic                          SER_WR_IN,
    input  wire logic                          SER_RD_IN,
    input  wire logic [`SCRS_SER_ADDR_W-1:0]   SER_ADDR_IN,
    input  wire logic [31:0]                   SER_WDATA_IN,
    output logic      [31:0]                   SER_RDATA_OUT,
    input  wire logic                          PAR_WR_IN,
    input  wire logic                          PAR_RD_IN,
    input  wire logic [`SCRS_PAR_ADDR_W-1:0]   PAR_ADDR_IN,
    input  wire logic [7:0]                    PAR_WDATA_IN,
    output logic      [7:0]                    PAR_RDATA_OUT,
    input  wire logic                          IO_UPDATE_IN,
    input  wire logic [2:0]                    PROFILE_SELECT_PINS_IN,
    input  wire logic [`SCRS_ROUTE_W-1:0]      PARAMETER_ROUTE_PINS_IN,
    input  wire logic [`SCRS_DATA_W-1:0]       STREAM_DATA_IN,
    output logic                               STREAM_READY_OUT,
    input  wire logic                          CORE_READY_IN,
    output logic                               OSCILLATOR_CALIBRATE_START_OUT,
    output logic                               STREAMING_ACTIVE_OUT,
    output logic                               SINE_SELECT_OUT,
    output logic                               RAMP_RATE_RELOAD_ON_STROBE_OUT,
    output logic                               RAMP_ACC_CLEAR_OUT,
    output logic      [31:0]                   FREQUENCY_TUNING_WORD_OUT,
    output logic      [`SCRS_PHASE_W-1:0]      PHASE_OFFSET_WORD_OUT,
    output logic      [`SCRS_SCALE_W-1:0]      OUTPUT_SCALE_WORD_OUT
);
    localparam int NREG = `SCRS_NUM_SER_REGS;
    localparam int FW   = `SCRS_ROUTE_W + `SCRS_DATA_W;

    // staged copies as seen by the host, and the active primary register
    scrs_pkg::scrs_word_t staged [NREG];
    scrs_pkg::scrs_word_t active_primary;

    logic [2:0]  profile_prev;
    logic        profile_change;
    logic        transfer;
    logic        cal_prev;
    logic        stream_en;
    logic        par_push;
    logic [FW-1:0] par_word;

    scrs_fifo_if #(.WIDTH(FW)) fifo_port ();

    // reset value of each staged register
    function automatic scrs_pkg::scrs_word_t reg_default(input int idx);
        reg_default = (idx == int'(`SCRS_PRIMARY_ADDR)) ? `SCRS_PRIMARY_RESET : 32'h0000_0000;
    endfunction : reg_default

    // open bits of the primary register never store a one
    function automatic scrs_pkg::scrs_word_t write_mask(input int idx,
                                                        input scrs_pkg::scrs_word_t w);
        if (idx == int'(`SCRS_PRIMARY_ADDR)) begin
            write_mask = w & `SCRS_PRIMARY_WMASK;
        end else begin
            write_mask = w;
        end
    endfunction : write_mask

    // byte lane of a staged word picked by a parallel address
    function automatic logic [7:0] byte_of(input scrs_pkg::scrs_word_t w,
                                           input logic [1:0] lane);
        byte_of = w[lane*8 +: 8];
    endfunction : byte_of

    // --------------------------------------------------------------
    // strobe and profile change detection
    // --------------------------------------------------------------
    assign profile_change = (PROFILE_SELECT_PINS_IN != profile_prev);
    assign transfer       = IO_UPDATE_IN || profile_change;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            profile_prev <= 3'h0;
        end else begin
            profile_prev <= PROFILE_SELECT_PINS_IN;
        end
    end

    // --------------------------------------------------------------
    // staging registers, written from either port
    // --------------------------------------------------------------
    // a serial and a parallel write in one cycle: the serial one wins
    // on a shared register, the trade being a simple single write path
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            for (int i = 0; i < NREG; i++) begin
                staged[i] <= reg_default(i);
            end
        end else if (MASTER_RESET_IN) begin
            for (int i = 0; i < NREG; i++) begin
                staged[i] <= reg_default(i);
            end
        end else begin
            if (PAR_WR_IN && PAR_ADDR_IN <= `SCRS_LAST_PAR_ADDR) begin
                staged[PAR_ADDR_IN[6:2]][PAR_ADDR_IN[1:0]*8 +: 8] <= byte_of(
                    write_mask(int'(PAR_ADDR_IN[6:2]), {4{PAR_WDATA_IN}}),
                    PAR_ADDR_IN[1:0]);
            end
            if (SER_WR_IN && SER_ADDR_IN <= `SCRS_LAST_SER_ADDR) begin
                staged[SER_ADDR_IN] <= write_mask(int'(SER_ADDR_IN), SER_WDATA_IN);
            end
        end
    end

    // --------------------------------------------------------------
    // read paths
    // --------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            SER_RDATA_OUT <= 32'h0000_0000;
        end else if (SER_RD_IN) begin
            if (SER_ADDR_IN <= `SCRS_LAST_SER_ADDR) begin
                SER_RDATA_OUT <= staged[SER_ADDR_IN];
            end else begin
                SER_RDATA_OUT <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            PAR_RDATA_OUT <= 8'h00;
        end else if (PAR_RD_IN) begin
            if (PAR_ADDR_IN <= `SCRS_LAST_PAR_ADDR) begin
                PAR_RDATA_OUT <= byte_of(staged[PAR_ADDR_IN[6:2]], PAR_ADDR_IN[1:0]);
            end else begin
                PAR_RDATA_OUT <= 8'h00;
            end
        end
    end

    // --------------------------------------------------------------
    // transfer of the primary register into the core
    // --------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            active_primary <= `SCRS_PRIMARY_RESET;
        end else if (MASTER_RESET_IN) begin
            active_primary <= `SCRS_PRIMARY_RESET;
        end else if (transfer) begin
            // all staged bits land on the same edge
            active_primary <= staged[`SCRS_PRIMARY_ADDR];
        end
    end

    assign stream_en = active_primary[`SCRS_BIT_STREAM_EN];

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            STREAMING_ACTIVE_OUT <= 1'b0;
            SINE_SELECT_OUT      <= 1'b1;
        end else begin
            STREAMING_ACTIVE_OUT <= stream_en;
            SINE_SELECT_OUT      <= active_primary[`SCRS_BIT_SINE_SEL];
        end
    end

    // calibration fires once per rising edge of the active bit, so the
    // host must return it to zero before another run can start
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cal_prev                       <= 1'b0;
            OSCILLATOR_CALIBRATE_START_OUT <= 1'b0;
        end else begin
            cal_prev                       <= active_primary[`SCRS_BIT_CAL_START];
            OSCILLATOR_CALIBRATE_START_OUT <= active_primary[`SCRS_BIT_CAL_START]
                                              && !cal_prev;
        end
    end

    // ramp controls act with the transfer itself, using the staged bits
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RAMP_RATE_RELOAD_ON_STROBE_OUT <= 1'b0;
            RAMP_ACC_CLEAR_OUT             <= 1'b0;
        end else begin
            RAMP_RATE_RELOAD_ON_STROBE_OUT <= transfer && !MASTER_RESET_IN
                && staged[`SCRS_PRIMARY_ADDR][`SCRS_BIT_RATE_RELOAD]
                && staged[`SCRS_SECONDARY_ADDR][`SCRS_BIT_RAMP_ENABLE];
            RAMP_ACC_CLEAR_OUT <= transfer && !MASTER_RESET_IN
                && staged[`SCRS_PRIMARY_ADDR][`SCRS_BIT_AUTOCLR_RAMP];
        end
    end

    // --------------------------------------------------------------
    // parallel data words into the buffer
    // --------------------------------------------------------------
    // streaming samples on every edge the buffer can take a word;
    // otherwise a word is taken only with the update strobe
    assign par_push = stream_en ? 1'b1 : IO_UPDATE_IN;
    assign par_word = {PARAMETER_ROUTE_PINS_IN, STREAM_DATA_IN};

    assign fifo_port.push_valid = par_push && !MASTER_RESET_IN;
    assign fifo_port.push_data  = par_word;
    assign fifo_port.pop_ready  = CORE_READY_IN;

    scrs_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .flush_in  (MASTER_RESET_IN),
        .port      (fifo_port.store)
    );

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            STREAM_READY_OUT <= 1'b0;
        end else begin
            // one cycle behind the buffer; a word offered while the buffer is full is lost
            STREAM_READY_OUT <= fifo_port.push_ready;
        end
    end

    // --------------------------------------------------------------
    // drain: route each word to its parameter
    // --------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            FREQUENCY_TUNING_WORD_OUT <= 32'h0000_0000;
            PHASE_OFFSET_WORD_OUT     <= 16'h0000;
            OUTPUT_SCALE_WORD_OUT     <= 12'h000;
        end else if (MASTER_RESET_IN) begin
            FREQUENCY_TUNING_WORD_OUT <= 32'h0000_0000;
            PHASE_OFFSET_WORD_OUT     <= 16'h0000;
            OUTPUT_SCALE_WORD_OUT     <= 12'h000;
        end else if (fifo_port.pop_valid && fifo_port.pop_ready) begin
            unique case (scrs_pkg::scrs_route_t'(fifo_port.pop_data[FW-1 -: 4]))
                scrs_pkg::SCRS_ROUTE_FREQ: begin
                    FREQUENCY_TUNING_WORD_OUT <= fifo_port.pop_data[31:0];
                end
                scrs_pkg::SCRS_ROUTE_PHASE: begin
                    PHASE_OFFSET_WORD_OUT <= fifo_port.pop_data[15:0];
                end
                scrs_pkg::SCRS_ROUTE_SCALE: begin
                    OUTPUT_SCALE_WORD_OUT <= fifo_port.pop_data[11:0];
                end
                scrs_pkg::SCRS_ROUTE_PHASE_SCALE: begin
                    PHASE_OFFSET_WORD_OUT <= fifo_port.pop_data[31:16];
                    OUTPUT_SCALE_WORD_OUT <= fifo_port.pop_data[11:0];
                end
                default: begin
                    // unused route codes drop the word
                end
            endcase
        end
    end
endmodule : scrs_top

// file: scrs_consts.svh
`ifndef SCRS_CONSTS_SVH
`define SCRS_CONSTS_SVH

// register map
`define SCRS_NUM_SER_REGS     28
`define SCRS_NUM_PAR_REGS     112
`define SCRS_SER_ADDR_W       5
`define SCRS_PAR_ADDR_W       7
`define SCRS_LAST_SER_ADDR    5'h1b
`define SCRS_LAST_PAR_ADDR    7'h6f
`define SCRS_PRIMARY_ADDR     5'h00
`define SCRS_SECONDARY_ADDR   5'h01

// primary control function fields
`define SCRS_BIT_CAL_START    24
`define SCRS_BIT_STREAM_EN    17
`define SCRS_BIT_SINE_SEL     16
`define SCRS_BIT_RATE_RELOAD  15
`define SCRS_BIT_AUTOCLR_RAMP 14
`define SCRS_PRIMARY_RESET    32'h0001_0008
`define SCRS_PRIMARY_WMASK    32'h0103_ffff

// secondary control function field
`define SCRS_BIT_RAMP_ENABLE  19

// streaming datapath
`define SCRS_DATA_W           32
`define SCRS_ROUTE_W          4
`define SCRS_FIFO_DEPTH       16
`define SCRS_PHASE_W          16
`define SCRS_SCALE_W          12

`endif

// file: scrs_pkg.sv
package scrs_pkg;

    // parameter chosen by the route pins for a parallel word
    typedef enum logic [3:0] {
        SCRS_ROUTE_FREQ,
        SCRS_ROUTE_PHASE,
        SCRS_ROUTE_SCALE,
        SCRS_ROUTE_PHASE_SCALE
    } scrs_route_t;

    typedef logic [31:0] scrs_word_t;

endpackage : scrs_pkg

// file: scrs_fifo_if.sv
`timescale 1ns/1ps

interface scrs_fifo_if #(
    parameter int WIDTH = 36
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport store (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );

    modport user (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface : scrs_fifo_if

// file: scrs_fifo.sv
`timescale 1ns/1ps

module scrs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic   clk_in,
    input  wire logic   arst_n_in,
    input  wire logic   flush_in,
    scrs_fifo_if.store  port
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             full;
    logic             do_push;
    logic             do_pop;

    assign do_push         = port.push_valid && !full;
    assign do_pop          = port.pop_valid && port.pop_ready;
    assign port.push_ready = !full;
    assign port.pop_valid  = (count != '0);
    assign port.pop_data   = mem[rd_ptr];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem[wr_ptr] <= port.push_data;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            // full is a flop so the source sees a registered ready
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
                full  <= (count == CW'(DEPTH - 1));
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
                full  <= 1'b0;
            end
        end
    end
endmodule : scrs_fifo

// file: scrs_host_model.sv
`timescale 1ns/1ps
module scrs_host_model (
    input  wire logic   clk_in,
    output logic        s_wr_out,
    output logic        s_rd_out,
    output logic [4:0]  s_addr_out,
    output logic [31:0] s_data_out,
    output logic        p_wr_out,
    output logic        p_rd_out,
    output logic [6:0]  p_addr_out,
    output logic [7:0]  p_data_out,
    output logic        upd_out,
    output logic [2:0]  prof_out,
    output logic [3:0]  route_out,
    output logic [31:0] data_out,
    output logic        rdy_out,
    output logic        mrst_out
);
    // idle route is a dropped code so plain strobes push nothing visible
    initial begin
        {s_wr_out, s_rd_out, p_wr_out, p_rd_out, upd_out, mrst_out} = 6'h00;
        {s_addr_out, s_data_out, p_addr_out, p_data_out} = 52'h0;
        {prof_out, data_out} = 35'h0;
        route_out = 4'hf;
        rdy_out = 1'b1;
    end
    task automatic ser(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        s_wr_out <= wr;
        s_rd_out <= !wr;
        s_addr_out <= a;
        s_data_out <= d;
        @(posedge clk_in);
        {s_wr_out, s_rd_out} <= 2'h0;
        s_data_out <= ~d;
    endtask : ser
    task automatic par(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        p_wr_out <= wr;
        p_rd_out <= !wr;
        p_addr_out <= a;
        p_data_out <= d;
        @(posedge clk_in);
        {p_wr_out, p_rd_out} <= 2'h0;
        p_data_out <= ~d;
    endtask : par
    task automatic word(input logic [3:0] r, input logic [31:0] d, input logic stb);
        @(posedge clk_in);
        route_out <= r;
        data_out <= d;
        upd_out <= stb;
        @(posedge clk_in);
        upd_out <= 1'b0;
        route_out <= 4'hf;
        data_out <= ~d;
    endtask : word
    task automatic burst(input logic [3:0] r, input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            route_out <= r;
            data_out <= b + 32'(i);
        end
        @(posedge clk_in);
        route_out <= 4'hf;
        data_out <= ~data_out;
    endtask : burst
    task automatic prof(input logic [2:0] p);
        @(posedge clk_in);
        prof_out <= p;
    endtask : prof
    task automatic ctl(input logic r);
        @(posedge clk_in);
        rdy_out <= r;
    endtask : ctl
    task automatic mrst();
        @(posedge clk_in);
        mrst_out <= 1'b1;
        @(posedge clk_in);
        mrst_out <= 1'b0;
    endtask : mrst
endmodule : scrs_host_model

// file: scrs_top_sva.sv
`timescale 1ns/1ps
module scrs_top_sva (
    input wire logic        CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        MASTER_RESET_IN,
    input wire logic        SER_RD_IN,
    input wire logic [4:0]  SER_ADDR_IN,
    input wire logic [31:0] SER_RDATA_OUT,
    input wire logic        PAR_RD_IN,
    input wire logic [6:0]  PAR_ADDR_IN,
    input wire logic [7:0]  PAR_RDATA_OUT,
    input wire logic        IO_UPDATE_IN,
    input wire logic [2:0]  PROFILE_SELECT_PINS_IN,
    input wire logic        OSCILLATOR_CALIBRATE_START_OUT,
    input wire logic        STREAMING_ACTIVE_OUT,
    input wire logic        SINE_SELECT_OUT,
    input wire logic        RAMP_RATE_RELOAD_ON_STROBE_OUT,
    input wire logic        RAMP_ACC_CLEAR_OUT,
    input wire logic [31:0] FREQUENCY_TUNING_WORD_OUT
);
    logic [2:0] prof_q;
    logic       xfer;
    logic [1:0] xfer_q;
    assign xfer = IO_UPDATE_IN | (PROFILE_SELECT_PINS_IN != prof_q);
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            prof_q <= 3'h0;
            xfer_q <= 2'h0;
        end else begin
            prof_q <= PROFILE_SELECT_PINS_IN;
            xfer_q <= {xfer_q[0], xfer};
        end
    end
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    a_stage_holds: assert property ((!xfer && !MASTER_RESET_IN)[*2] |=>
        $stable(SINE_SELECT_OUT) && $stable(STREAMING_ACTIVE_OUT)) else $error("staged leak");
    a_clear_cause: assert property ($rose(RAMP_ACC_CLEAR_OUT) |-> |xfer_q)
        else $error("ramp clear without transfer");
    a_reload_cause: assert property ($rose(RAMP_RATE_RELOAD_ON_STROBE_OUT) |-> |xfer_q)
        else $error("reload without transfer");
    a_cal_pulse: assert property (OSCILLATOR_CALIBRATE_START_OUT |=>
        !OSCILLATOR_CALIBRATE_START_OUT) else $error("calibrate not a pulse");
    a_ser_range: assert property (SER_RD_IN && SER_ADDR_IN > 5'h1b |=>
        SER_RDATA_OUT == 32'h0) else $error("unmapped serial read");
    a_open_bits: assert property (SER_RD_IN && SER_ADDR_IN == 5'h00 |=>
        (SER_RDATA_OUT & 32'hfefc_0000) == 32'h0) else $error("open bits set");
    a_par_range: assert property (PAR_RD_IN && PAR_ADDR_IN > 7'h6f |=>
        PAR_RDATA_OUT == 8'h00) else $error("unmapped parallel read");
    a_mreset_words: assert property (MASTER_RESET_IN |-> ##[1:2]
        FREQUENCY_TUNING_WORD_OUT == 32'h0) else $error("word kept over reset");
endmodule : scrs_top_sva
bind scrs_top scrs_top_sva u_sva (
    .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .MASTER_RESET_IN(MASTER_RESET_IN),
    .SER_RD_IN(SER_RD_IN), .SER_ADDR_IN(SER_ADDR_IN), .SER_RDATA_OUT(SER_RDATA_OUT),
    .PAR_RD_IN(PAR_RD_IN), .PAR_ADDR_IN(PAR_ADDR_IN), .PAR_RDATA_OUT(PAR_RDATA_OUT),
    .IO_UPDATE_IN(IO_UPDATE_IN), .PROFILE_SELECT_PINS_IN(PROFILE_SELECT_PINS_IN),
    .OSCILLATOR_CALIBRATE_START_OUT(OSCILLATOR_CALIBRATE_START_OUT),
    .STREAMING_ACTIVE_OUT(STREAMING_ACTIVE_OUT), .SINE_SELECT_OUT(SINE_SELECT_OUT),
    .RAMP_RATE_RELOAD_ON_STROBE_OUT(RAMP_RATE_RELOAD_ON_STROBE_OUT),
    .RAMP_ACC_CLEAR_OUT(RAMP_ACC_CLEAR_OUT),
    .FREQUENCY_TUNING_WORD_OUT(FREQUENCY_TUNING_WORD_OUT)
);

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int DEPTH = 16;
    logic        clk, arst_n, s_wr, s_rd, p_wr, p_rd, upd, mrst, rdy;
    logic        s_rdy, cal, act, sine, rld, clr;
    logic [4:0]  s_addr;
    logic [31:0] s_wd, s_rdat, data, freq_word;
    logic [6:0]  p_addr;
    logic [7:0]  p_wd, p_rdat;
    logic [2:0]  prof;
    logic [3:0]  route;
    logic [15:0] phase;
    logic [11:0] scale;
    logic [7:0]  n_cal = 8'h00, n_clr = 8'h00, n_rld = 8'h00;
    int          n_errors = 0;
    int          samples_checked = 0;
    scrs_host_model host (.clk_in(clk), .s_wr_out(s_wr), .s_rd_out(s_rd), .s_addr_out(s_addr),
        .s_data_out(s_wd), .p_wr_out(p_wr), .p_rd_out(p_rd), .p_addr_out(p_addr),
        .p_data_out(p_wd), .upd_out(upd), .prof_out(prof), .route_out(route),
        .data_out(data), .rdy_out(rdy), .mrst_out(mrst));
    scrs_top #(.FIFO_DEPTH(DEPTH)) dut (.CLK_IN(clk), .ARST_N_IN(arst_n),
        .MASTER_RESET_IN(mrst), .SER_WR_IN(s_wr), .SER_RD_IN(s_rd), .SER_ADDR_IN(s_addr),
        .SER_WDATA_IN(s_wd), .SER_RDATA_OUT(s_rdat), .PAR_WR_IN(p_wr), .PAR_RD_IN(p_rd),
        .PAR_ADDR_IN(p_addr), .PAR_WDATA_IN(p_wd), .PAR_RDATA_OUT(p_rdat),
        .IO_UPDATE_IN(upd), .PROFILE_SELECT_PINS_IN(prof), .PARAMETER_ROUTE_PINS_IN(route),
        .STREAM_DATA_IN(data), .STREAM_READY_OUT(s_rdy), .CORE_READY_IN(rdy),
        .OSCILLATOR_CALIBRATE_START_OUT(cal), .STREAMING_ACTIVE_OUT(act),
        .SINE_SELECT_OUT(sine), .RAMP_RATE_RELOAD_ON_STROBE_OUT(rld),
        .RAMP_ACC_CLEAR_OUT(clr), .FREQUENCY_TUNING_WORD_OUT(freq_word),
        .PHASE_OFFSET_WORD_OUT(phase), .OUTPUT_SCALE_WORD_OUT(scale));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // pulses counted mid-cycle so the tasks reading at the rising edge never race them
    always @(negedge clk) begin
        n_cal <= n_cal + 8'(cal === 1'b1);
        n_clr <= n_clr + 8'(clr === 1'b1);
        n_rld <= n_rld + 8'(rld === 1'b1);
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rs(input logic [4:0] a, input logic [31:0] e);
        host.ser(1'b0, a, 32'h0);
        @(posedge clk);
        chk(s_rdat, e);
    endtask : rs
    task automatic rp(input logic [6:0] a, input logic [7:0] e);
        host.par(1'b0, a, 8'h00);
        @(posedge clk);
        chk({24'h0, p_rdat}, {24'h0, e});
    endtask : rp
    // e holds the expected number of calibrate, ramp clear and reload pulses
    task automatic xfer(input logic [2:0] p, input logic [23:0] e);
        logic [23:0] base;
        base = {n_cal, n_clr, n_rld};
        if (p === prof) begin
            host.word(4'hf, 32'h0, 1'b1);
        end else begin
            host.prof(p);
        end
        repeat (6) @(posedge clk);
        chk({8'h00, {n_cal, n_clr, n_rld} - base}, {8'h00, e});
    endtask : xfer
    task automatic t_regs();
        rs(5'h00, 32'h0001_0008);
        chk({31'h0, sine}, 32'h1);
        host.ser(1'b1, 5'h00, 32'hfeff_ffff);
        rs(5'h00, 32'h0003_ffff);
        host.ser(1'b1, 5'h1c, 32'hffff_ffff);
        rs(5'h1c, 32'h0);
        host.ser(1'b1, 5'h1b, 32'h1234_5678);
        rs(5'h1b, 32'h1234_5678);
        host.mrst();
        rs(5'h00, 32'h0001_0008);
        rs(5'h1b, 32'h0);
        host.par(1'b1, 7'h6e, 8'ha5);
        rp(7'h6e, 8'ha5);
        rs(5'h1b, 32'h00a5_0000);
        rp(7'h70, 8'h00);
    endtask : t_regs
    task automatic t_stage();
        host.par(1'b1, 7'h02, 8'h00);
        rs(5'h00, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk({31'h0, sine}, 32'h1);
        xfer(prof, 24'h0);
        chk({31'h0, sine}, 32'h0);
        host.ser(1'b1, 5'h00, 32'h0001_0008);
        xfer(3'h5, 24'h0);
        chk({31'h0, sine}, 32'h1);
    endtask : t_stage
    task automatic t_ramp();
        host.ser(1'b1, 5'h00, 32'h0101_0008);
        xfer(prof, 24'h01_00_00);
        xfer(prof, 24'h0);
        host.ser(1'b1, 5'h00, 32'h0001_0008);
        xfer(prof, 24'h0);
        host.ser(1'b1, 5'h00, 32'h0101_c008);
        xfer(prof, 24'h01_01_00);
        host.ser(1'b1, 5'h01, 32'h0008_0000);
        xfer(3'h2, 24'h00_01_01);
        host.ser(1'b1, 5'h00, 32'h0001_8008);
        xfer(prof, 24'h00_00_01);
    endtask : t_ramp
    task automatic t_stream();
        host.word(4'h0, 32'hcafe_0001, 1'b1);
        host.word(4'h0, 32'h1111_1111, 1'b0);
        repeat (4) @(posedge clk);
        chk(freq_word, 32'hcafe_0001);
        host.word(4'h3, 32'h5678_0def, 1'b1);
        repeat (4) @(posedge clk);
        chk({phase, 4'h0, scale}, 32'h5678_0def);
        host.ctl(1'b0);
        for (int i = 0; i < DEPTH + 4; i++) begin
            host.word(4'h0, 32'h2000_0000 + 32'(i), 1'b1);
        end
        repeat (2) @(posedge clk);
        chk({31'h0, s_rdy}, 32'h0);
        chk(freq_word, 32'hcafe_0001);
        host.ctl(1'b1);
        repeat (DEPTH * 3) @(posedge clk);
        chk(freq_word, 32'h2000_0000 + 32'(DEPTH - 1));
        chk({31'h0, s_rdy}, 32'h1);
        host.ser(1'b1, 5'h00, 32'h0003_0008);
        xfer(prof, 24'h0);
        chk({31'h0, act}, 32'h1);
        host.burst(4'h1, 32'h0000_7000, 5);
        repeat (4) @(posedge clk);
        chk({16'h0, phase}, 32'h0000_7004);
        host.burst(4'h2, 32'h0000_0abc, 1);
        repeat (4) @(posedge clk);
        chk({phase, 4'h0, scale}, 32'h7004_0abc);
        // master reset while streaming, with a live word on the outputs
        host.mrst();
        repeat (2) @(posedge clk);
        chk(freq_word, 32'h0);
        chk({31'h0, act}, 32'h0);
    endtask : t_stream
    initial begin
        #300us;
        n_errors++;
        print_verdict();
    end
    initial begin
        arst_n = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        host.mrst();
        t_regs();
        t_stage();
        t_ramp();
        t_stream();
        print_verdict();
    end
endmodule : tb_top
